/* File: hw/module_power_reset_sequencer.sv */
`timescale 1ns/10ps
`default_nettype none
module module_power_reset_sequencer #(
	parameter logic [31:0] INIT_CYC = 32'(pwrseq_pkg::INIT_CYCLES),
	parameter logic [31:0] SD_CYC   = 32'(pwrseq_pkg::SHUTDOWN_CYCLES),
	parameter logic [31:0] RST_CYC  = 32'(pwrseq_pkg::RESTART_MIN_CYCLES)
) (
	// clock and reset
	input  wire logic            clk_sys,
	input  wire logic            rst,
	input  wire logic            ce,
	// pins from host, asynchronous
	input  wire logic            full_card_power_en,
	input  wire logic            modem_restart_n,
	input  wire logic            pcie_fundamental_rst_n,
	input  wire logic            pcie_present,
	input  wire logic            usb_present,
	input  wire logic            d3cold_req,
	// internal firmware side, same clock
	input  wire logic            sw_shutdown_cmd,
	input  wire logic            save_done,
	input  wire logic            clear_done,
	input  wire logic            core_dump,
	// status and control
	output pwrseq_pkg::ctrl_t    ctrl,
	output pwrseq_pkg::seq_state_t state,
	output logic                 init_done,
	output logic                 shutdown_ok,
	output logic                 save_req,
	output logic                 clear_req,
	output logic                 pcie_d3cold
);
	logic [5:0] s1_r, s2_r;
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			s1_r <= 6'h3f;
			s2_r <= 6'h3f;
		end else if (ce) begin
			s1_r <= {full_card_power_en, modem_restart_n,
				pcie_fundamental_rst_n, pcie_present, usb_present,
				d3cold_req};
			s2_r <= s1_r;
		end
	end
	// fsm waits until both sync stages hold real pin values
	logic [1:0] fill_r;
	always_ff @(posedge clk_sys) begin
		if (rst)
			fill_r <= 2'h0;
		else if (ce)
			fill_r <= {fill_r[0], 1'b1};
	end
	wire pins_valid = fill_r[1];
	wire pwr_en   = s2_r[5];
	wire rstin_n  = s2_r[4];
	wire pcie_fundamental_rst_n_n  = s2_r[3];
	wire pcie_p   = s2_r[2];
	wire usb_p    = s2_r[1];
	wire d3_req   = s2_r[0];

	pwrseq_pkg::seq_state_t st_r, st_nxt;
	logic [31:0] cnt_r, cnt_nxt;
	logic        long_r, long_nxt;
	wire cnt_done = (cnt_r == pwrseq_pkg::CNT_ZERO);
	wire cnt_dec  = !cnt_done;

	// pull-up pin: a floating input reads high
	wire power_off = !pwr_en;

	always_comb begin
		st_nxt   = st_r;
		cnt_nxt  = cnt_dec ? cnt_r - pwrseq_pkg::CNT_ONE : cnt_r;
		long_nxt = long_r;
		unique case (st_r)
			pwrseq_pkg::ST_OFF: begin
				if (pins_valid && !power_off && rstin_n) begin
					st_nxt  = pwrseq_pkg::ST_INIT;
					cnt_nxt = INIT_CYC;
				end
			end
			pwrseq_pkg::ST_INIT: begin
				if (cnt_done)
					st_nxt = pwrseq_pkg::ST_RUN;
			end
			pwrseq_pkg::ST_RUN: begin
				if (sw_shutdown_cmd) begin
					st_nxt  = pwrseq_pkg::ST_SAVE;
					cnt_nxt = SD_CYC;
				end
			end
			pwrseq_pkg::ST_SAVE: begin
				if (save_done)
					st_nxt = pwrseq_pkg::ST_CLEAR;
			end
			pwrseq_pkg::ST_CLEAR: begin
				if (clear_done)
					st_nxt = pwrseq_pkg::ST_PMU_DOWN;
			end
			pwrseq_pkg::ST_PMU_DOWN: begin
				if (power_off)
					st_nxt = pwrseq_pkg::ST_OFF;
			end
			pwrseq_pkg::ST_RESTART: begin
				if (cnt_done)
					long_nxt = 1'b1;
				if (rstin_n) begin
					// restart only after a long enough pulse
					st_nxt  = (long_r || cnt_done) ?
						pwrseq_pkg::ST_INIT : pwrseq_pkg::ST_RUN;
					cnt_nxt = INIT_CYC;
				end
			end
			default: st_nxt = pwrseq_pkg::ST_OFF;
		endcase
		// restart pin in any powered state
		if (!rstin_n && st_r != pwrseq_pkg::ST_OFF &&
			st_r != pwrseq_pkg::ST_RESTART &&
			st_r != pwrseq_pkg::ST_PMU_DOWN) begin
			st_nxt   = pwrseq_pkg::ST_RESTART;
			cnt_nxt  = RST_CYC;
			long_nxt = 1'b0;
		end
		// shutdown bounded when finalization stalls
		if ((st_r == pwrseq_pkg::ST_SAVE || st_r == pwrseq_pkg::ST_CLEAR)
			&& cnt_done)
			st_nxt = pwrseq_pkg::ST_PMU_DOWN;
		// hardware power-off has top priority in every state except ST_RESTART
		if (power_off && st_r != pwrseq_pkg::ST_RESTART)
			st_nxt = pwrseq_pkg::ST_OFF;
	end

	wire in_restart = (st_r == pwrseq_pkg::ST_RESTART);
	wire powered = (st_r != pwrseq_pkg::ST_OFF) &&
		(st_r != pwrseq_pkg::ST_PMU_DOWN);
	wire pmu_on_w = powered || in_restart;
	wire running = (st_r == pwrseq_pkg::ST_RUN);
	wire core_rst_w = !powered || in_restart ||
		(!pcie_fundamental_rst_n_n && core_dump);
	wire pcie_rst_w = !powered || !pcie_fundamental_rst_n_n;
	wire pcie_en_w = running && pcie_p;
	wire usb_en_w = running && usb_p && !pcie_p;
	wire d3_w = running && pcie_p && d3_req && !pcie_fundamental_rst_n_n;

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			st_r        <= pwrseq_pkg::ST_OFF;
			cnt_r       <= pwrseq_pkg::CNT_ZERO;
			long_r      <= 1'b0;
			ctrl        <= '{pmu_on: 1'b0, core_rst: 1'b1, pcie_rst: 1'b1,
				usb_en: 1'b0, pcie_en: 1'b0};
			state       <= pwrseq_pkg::ST_OFF;
			init_done   <= 1'b0;
			shutdown_ok <= 1'b0;
			save_req    <= 1'b0;
			clear_req   <= 1'b0;
			pcie_d3cold <= 1'b0;
		end else if (ce) begin
			st_r        <= st_nxt;
			cnt_r       <= cnt_nxt;
			long_r      <= long_nxt;
			ctrl        <= '{pmu_on: pmu_on_w, core_rst: core_rst_w,
				pcie_rst: pcie_rst_w, usb_en: usb_en_w, pcie_en: pcie_en_w};
			state       <= st_r;
			init_done   <= running;
			shutdown_ok <= (st_r != pwrseq_pkg::ST_PMU_DOWN) &&
				(st_nxt == pwrseq_pkg::ST_PMU_DOWN);
			save_req    <= (st_r == pwrseq_pkg::ST_SAVE);
			clear_req   <= (st_r == pwrseq_pkg::ST_CLEAR);
			pcie_d3cold <= d3_w;
		end
	end

	a_pmu_restart: assert property (@(posedge clk_sys) disable iff (rst)
		ce && st_r == pwrseq_pkg::ST_RESTART |=> ctrl.pmu_on)
		else $error("power manager dropped during restart");
	a_poweroff_st: assert property (@(posedge clk_sys) disable iff (rst)
		ce && power_off && st_r != pwrseq_pkg::ST_RESTART
		|=> st_r == pwrseq_pkg::ST_OFF)
		else $error("power enable low did not power off");
	a_init_order: assert property (@(posedge clk_sys) disable iff (rst)
		ce && st_r == pwrseq_pkg::ST_OFF && st_nxt == pwrseq_pkg::ST_INIT
		|=> cnt_r == INIT_CYC)
		else $error("init timer not loaded");
	a_final_seq: assert property (@(posedge clk_sys) disable iff (rst)
		st_r == pwrseq_pkg::ST_CLEAR |-> $past(st_r) inside
		{pwrseq_pkg::ST_SAVE, pwrseq_pkg::ST_CLEAR})
		else $error("clear before save");
	a_usb_prio: assert property (@(posedge clk_sys) disable iff (rst)
		!(ctrl.usb_en && ctrl.pcie_en))
		else $error("usb enabled alongside pcie");
	a_pcie_scope: assert property (@(posedge clk_sys) disable iff (rst)
		ce && running && !pcie_fundamental_rst_n_n && !core_dump && rstin_n
		|=> ctrl.pcie_rst && !ctrl.core_rst)
		else $error("pcie reset scope wrong");
	a_sd_ok: assert property (@(posedge clk_sys) disable iff (rst)
		$rose(shutdown_ok) |-> $past(st_r) == pwrseq_pkg::ST_SAVE ||
		$past(st_r) == pwrseq_pkg::ST_CLEAR)
		else $error("ok without finalization");
	a_restart_ent: assert property (@(posedge clk_sys) disable iff (rst)
		ce && running && !rstin_n && !power_off
		|=> st_r == pwrseq_pkg::ST_RESTART && cnt_r == RST_CYC)
		else $error("restart pin ignored");
	a_boot_hold: assert property (@(posedge clk_sys) disable iff (rst)
		ce && !pins_valid |=> st_r == pwrseq_pkg::ST_OFF)
		else $error("left off before pins settled");
endmodule // module_power_reset_sequencer
`default_nettype wire

/* File: hw/pwrseq_pkg.sv */
package pwrseq_pkg;
	localparam int CLK_HZ = 100_000_000;
	localparam int INIT_TIME_S = 10;
	localparam int SHUTDOWN_MAX_S = 5;
	localparam int RESTART_MIN_MS = 10;
	localparam longint INIT_CYCLES = longint'(INIT_TIME_S) * CLK_HZ;
	localparam longint SHUTDOWN_CYCLES = longint'(SHUTDOWN_MAX_S) * CLK_HZ;
	localparam longint RESTART_MIN_CYCLES =
		(longint'(RESTART_MIN_MS) * CLK_HZ + 999) / 1000;
	localparam int CNT_W = 32;
	localparam logic [CNT_W-1:0] CNT_ZERO = 32'h0000_0000;
	localparam logic [CNT_W-1:0] CNT_ONE = 32'h0000_0001;

	typedef enum logic [2:0] {
		ST_OFF      = 3'b000,
		ST_INIT     = 3'b001,
		ST_RUN      = 3'b010,
		ST_SAVE     = 3'b011,
		ST_CLEAR    = 3'b100,
		ST_PMU_DOWN = 3'b101,
		ST_RESTART  = 3'b110
	} seq_state_t;

	typedef struct packed {
		logic pmu_on;
		logic core_rst;
		logic pcie_rst;
		logic usb_en;
		logic pcie_en;
	} ctrl_t;
endpackage

/* File: test/host_model.sv */
`timescale 1ns/10ps
`default_nettype none
module host_model #(
	parameter int MS = 2
) (
	// clock
	input  wire logic clk_sys,
	// host outputs, each on its own line
	output var logic  power_en,
	output var logic  restart_n,
	output var logic  pcie_fundamental_rst_n
);
	initial begin
		power_en = 1'b0;
		restart_n = 1'b0;
		pcie_fundamental_rst_n = 1'b0;
	end
	task automatic hold(input int ms);
		repeat (ms * MS) @(negedge clk_sys);
	endtask
	task automatic power_on();
		restart_n = 1'b1;
		hold(30);
		power_en = 1'b1;
		hold(30);
		pcie_fundamental_rst_n = 1'b1;
	endtask
	// pcie reset left high, it is optional here
	task automatic restart(input int cyc);
		restart_n = 1'b0;
		repeat (cyc) @(negedge clk_sys);
		restart_n = 1'b1;
	endtask
	// only after the command shutdown has reached ST_PMU_DOWN
	task automatic power_off();
		restart_n = 1'b0;
		hold(15);
		pcie_fundamental_rst_n = 1'b0;
		hold(15);
		power_en = 1'b0;
	endtask
	task automatic pcie_reset(input logic level_n);
		pcie_fundamental_rst_n = level_n;
	endtask
endmodule // host_model
`default_nettype wire

/* File: test/tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
module tb_top;
	logic                   clk_sys, rst, sw_cmd, save_done, clear_done;
	logic                   power_en, restart_n, pcie_fundamental_rst_n_n;
	pwrseq_pkg::ctrl_t      ctrl;
	pwrseq_pkg::seq_state_t st;
	logic                   ok, save_req, clear_req;
	logic                   ce, pcie_p, usb_p, d3_req, cdump;
	logic                   init_done, d3cold;
	logic [3:0]             e_note;
	pwrseq_pkg::seq_state_t st_seen = pwrseq_pkg::ST_OFF;
	logic [3:0]             q[$];
	int                     fails, samples_checked, ok_cnt;
	host_model h (.clk_sys(clk_sys), .power_en(power_en),
		.restart_n(restart_n), .pcie_fundamental_rst_n(pcie_fundamental_rst_n_n));
	module_power_reset_sequencer #(.INIT_CYC(32'h0000_00c8),
		.SD_CYC(32'h0000_0064), .RST_CYC(32'h0000_0014)) uut (
		.clk_sys(clk_sys), .rst(rst), .ce(ce),
		.full_card_power_en(power_en), .modem_restart_n(restart_n),
		.pcie_fundamental_rst_n(pcie_fundamental_rst_n_n), .pcie_present(pcie_p),
		.usb_present(usb_p), .d3cold_req(d3_req), .sw_shutdown_cmd(sw_cmd),
		.save_done(save_done), .clear_done(clear_done), .core_dump(cdump),
		.ctrl(ctrl), .state(st), .init_done(init_done), .shutdown_ok(ok),
		.save_req(save_req), .clear_req(clear_req), .pcie_d3cold(d3cold));
	wire [3:0] seen_note = {ctrl.pmu_on, st};
	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end
	task automatic chk(input string n, input logic [3:0] e, input logic [3:0] g);
		samples_checked++;
		if (g !== e) begin
			fails++;
			$display("BAD %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic chk_ctrl(input string n, input logic [4:0] e);
		samples_checked++;
		if (ctrl !== e) begin
			fails++;
			$display("BAD %s expected %h seen %h", n, e, ctrl);
		end
	endtask
	task automatic chk_bit(input string n, input logic e, input logic g);
		samples_checked++;
		if (g !== e) begin
			fails++;
			$display("BAD %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic ex(input pwrseq_pkg::seq_state_t s);
		q.push_back({s != pwrseq_pkg::ST_OFF && s != pwrseq_pkg::ST_PMU_DOWN, s});
	endtask
	task automatic wait_st(input pwrseq_pkg::seq_state_t s);
		for (int i = 0; i < 3000 && st !== s; i++) @(negedge clk_sys);
		if (st !== s) chk("wait", 4'(s), 4'(st));
	endtask
	task automatic report_and_stop();
		$display("checked %0d fails %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	task automatic cmd_shutdown(input bit answer);
		sw_cmd = 1'b1;
		@(negedge clk_sys) sw_cmd = 1'b0;
		if (answer) begin
			wait_st(pwrseq_pkg::ST_SAVE);
			chk_bit("save_req", 1'b1, save_req);
			save_done = 1'b1;
			@(negedge clk_sys) save_done = 1'b0;
			wait_st(pwrseq_pkg::ST_CLEAR);
			chk_bit("clear_req", 1'b1, clear_req);
			clear_done = 1'b1;
			@(negedge clk_sys) clear_done = 1'b0;
		end
		wait_st(pwrseq_pkg::ST_PMU_DOWN);
		h.power_off();
		wait_st(pwrseq_pkg::ST_OFF);
		repeat (4) @(negedge clk_sys);
	endtask
	always @(negedge clk_sys) if (ok === 1'b1) ok_cnt++;
	always @(negedge clk_sys) begin : watch
		if (!rst && st !== st_seen) begin
			st_seen = st;
			e_note = q.size() > 0 ? q.pop_front() : 4'hf;
			chk("state", e_note, seen_note);
		end
	end
	initial begin
		repeat (20000) @(posedge clk_sys);
		fails++;
		report_and_stop();
	end
	initial begin
		rst = 1'b1;
		sw_cmd = 1'b0;
		save_done = 1'b0;
		clear_done = 1'b0;
		ce = 1'b1;
		pcie_p = 1'b1;
		usb_p = 1'b1;
		d3_req = 1'b0;
		cdump = 1'b0;
		void'($urandom(32'hb84916e4));
		repeat (5) @(negedge clk_sys);
		rst = 1'b0;
		ex(pwrseq_pkg::ST_INIT);
		ex(pwrseq_pkg::ST_RUN);
		h.power_on();
		wait_st(pwrseq_pkg::ST_RUN);
		$display("test power_on done");
		ex(pwrseq_pkg::ST_RESTART);
		ex(pwrseq_pkg::ST_INIT);
		ex(pwrseq_pkg::ST_RUN);
		h.restart(40 + $urandom % 40);
		repeat (10) @(negedge clk_sys);
		wait_st(pwrseq_pkg::ST_RUN);
		ex(pwrseq_pkg::ST_RESTART);
		ex(pwrseq_pkg::ST_RUN);
		h.restart(4 + $urandom % 12);
		repeat (30) @(negedge clk_sys);
		$display("test restart done");
		chk_ctrl("ctrl_run", 5'h11);
		chk_bit("init_done", 1'b1, init_done);
		ce = 1'b0;
		pcie_p = 1'b0;
		repeat (6) @(negedge clk_sys);
		chk_ctrl("ctrl_frozen", 5'h11);
		ce = 1'b1;
		repeat (4) @(negedge clk_sys);
		chk_ctrl("ctrl_usb_only", 5'h12);
		pcie_p = 1'b1;
		d3_req = 1'b1;
		h.pcie_reset(1'b0);
		repeat (4) @(negedge clk_sys);
		chk_ctrl("ctrl_pcie_rst", 5'h15);
		chk_bit("pcie_d3cold", 1'b1, d3cold);
		cdump = 1'b1;
		repeat (2) @(negedge clk_sys);
		chk_ctrl("ctrl_core_rst", 5'h1d);
		cdump = 1'b0;
		d3_req = 1'b0;
		h.pcie_reset(1'b1);
		repeat (4) @(negedge clk_sys);
		chk_ctrl("ctrl_back", 5'h11);
		chk_bit("pcie_d3cold", 1'b0, d3cold);
		$display("test ports done");
		ex(pwrseq_pkg::ST_SAVE);
		ex(pwrseq_pkg::ST_CLEAR);
		ex(pwrseq_pkg::ST_PMU_DOWN);
		ex(pwrseq_pkg::ST_OFF);
		cmd_shutdown(1'b1);
		ex(pwrseq_pkg::ST_INIT);
		ex(pwrseq_pkg::ST_RUN);
		h.power_on();
		wait_st(pwrseq_pkg::ST_RUN);
		ex(pwrseq_pkg::ST_SAVE);
		ex(pwrseq_pkg::ST_PMU_DOWN);
		ex(pwrseq_pkg::ST_OFF);
		cmd_shutdown(1'b0);
		chk("ok_pulses", 4'h2, ok_cnt[3:0]);
		chk("queue_left", 4'h0, 4'(q.size()));
		$display("test shutdown done");
		report_and_stop();
	end
endmodule // tb_top
`default_nettype wire
